// [pkg/reg_bridge_consts.vh]
// Address layout, register indices and timing counts for the register bridge
`ifndef REG_BRIDGE_CONSTS_VH
`define REG_BRIDGE_CONSTS_VH

// Word address: 13 bits cover bytes 0x0000-0x7FFF
`define WADDR_W        13
// Session select field, word address bits [12:11] (8 KB per session)
`define SEL_HI         12
`define SEL_LO         11
// Area select, word address bit 10 (byte offset 0x1000 inside a session)
`define AREA_BIT       10
// Low word address bits fed to both areas (bytes 0x00-0xFF)
`define LOC_AW         6
`define LANES          4
`define SEL_W          2

// Local test register word indices (byte offset 0x1000 + 4 * index)
`define LREG_CTRL      6'h00
`define LREG_TXLEN     6'h01
`define LREG_TXCNT     6'h02
`define LREG_RXCNT     6'h03
`define LREG_STAT      6'h04

// Control register fields
`define CTRL_TX_EN     0
`define CTRL_RX_EN     1
`define CTRL_CLR_FAIL  2

// Status register fields
`define STAT_FAIL      0
`define STAT_TX_BUSY   1

// Cycles after the issue pulse until a write has left the switch
`define WR_DRAIN       2'h2

`endif

// [rtl/cpu_register_adapter.v]
// CPU bus to four-session register bridge with per-session test blocks
`timescale 1ns/100ps
`include "reg_bridge_consts.vh"

// One session: local test registers, pattern source and pattern checker
module session_test_block #(
  parameter FIFO_W = 512
) (
  input  wire                 clk,
  input  wire                 rst_n,
  input  wire                 wr,
  input  wire                 rd,
  input  wire [`WADDR_W-1:0]  addr,
  input  wire [31:0]          wdata,
  input  wire [`LANES-1:0]    mask,
  output wire                 eng_wr,
  output wire [`LOC_AW-1:0]   eng_addr,
  output wire [31:0]          eng_wdata,
  output wire [`LANES-1:0]    eng_mask,
  output wire                 eng_rd,
  input  wire [31:0]          eng_rdata,
  input  wire                 eng_done,
  output wire [31:0]          rdata,
  output wire                 done,
  output wire                 tx_write,
  output wire [FIFO_W-1:0]    tx_word,
  input  wire                 tx_full,
  output wire                 rx_read,
  input  wire [FIFO_W-1:0]    rx_word,
  input  wire                 rx_empty,
  output wire                 fail
);

  function [FIFO_W-1:0] pattern_word;
    input [31:0] seed;
    integer k;
    begin
      pattern_word = {FIFO_W{1'b0}};
      for (k = 0; k < FIFO_W / 32; k = k + 1) begin
        pattern_word[k*32 +: 32] = seed + k;
      end
    end
  endfunction

  wire          local_area = addr[`AREA_BIT];
  wire [`LOC_AW-1:0] idx   = addr[`LOC_AW-1:0];
  wire          wr_loc     = wr & local_area;
  wire          wr_ctrl    = wr_loc & (idx == `LREG_CTRL);

  reg  [2:0]    ctrl_r;
  reg  [31:0]   txlen_r;
  reg  [31:0]   txcnt_r;
  reg  [31:0]   rxcnt_r;
  reg           fail_r;
  reg           chk_pend_r;
  reg  [31:0]   rdata_r;
  reg           done_r;
  reg  [31:0]   rd_mux;

  // Engine area gets the low bits and the lane mask untouched
  assign eng_wr    = wr & ~local_area;
  assign eng_rd    = rd & ~local_area;
  assign eng_addr  = idx;
  assign eng_wdata = wdata;
  assign eng_mask  = mask;

  // Local registers ignore the mask; TXLEN takes all 32 bits, CTRL only bits [2:0]
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r  <= 3'h0;
      txlen_r <= 32'h00000000;
    end else begin
      ctrl_r[`CTRL_CLR_FAIL] <= 1'b0;
      if (wr_ctrl) begin
        ctrl_r <= wdata[2:0];
      end
      if (wr_loc && idx == `LREG_TXLEN) begin
        txlen_r <= wdata;
      end
    end
  end

  // Pattern source: writes while enabled, below the length and not full
  assign tx_write = ctrl_r[`CTRL_TX_EN] & (txcnt_r < txlen_r)
                    & ~tx_full;
  assign tx_word  = pattern_word(txcnt_r);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txcnt_r <= 32'h00000000;
    end else if (wr_ctrl) begin
      txcnt_r <= 32'h00000000;
    end else if (tx_write) begin
      txcnt_r <= txcnt_r + 32'h00000001;
    end
  end

  // Pattern checker: FIFO data is valid the cycle after the read
  assign rx_read = ctrl_r[`CTRL_RX_EN] & ~rx_empty;
  assign fail    = fail_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_pend_r <= 1'b0;
      rxcnt_r    <= 32'h00000000;
      fail_r     <= 1'b0;
    end else begin
      chk_pend_r <= rx_read;
      if (wr_ctrl && !wdata[`CTRL_RX_EN]) begin
        rxcnt_r <= 32'h00000000;
      end else if (chk_pend_r) begin
        rxcnt_r <= rxcnt_r + 32'h00000001;
      end
      // A mismatch in the clearing cycle still sets the flag
      if (chk_pend_r && rx_word != pattern_word(rxcnt_r)) begin
        fail_r <= 1'b1;
      end else if (ctrl_r[`CTRL_CLR_FAIL]) begin
        fail_r <= 1'b0;
      end
    end
  end

  always @* begin
    case (idx)
      `LREG_CTRL:  rd_mux = {29'h00000000, ctrl_r};
      `LREG_TXLEN: rd_mux = txlen_r;
      `LREG_TXCNT: rd_mux = txcnt_r;
      `LREG_RXCNT: rd_mux = rxcnt_r;
      `LREG_STAT:  rd_mux = {30'h00000000, tx_write | (txcnt_r < txlen_r),
                             fail_r};
      default:     rd_mux = 32'h00000000;
    endcase
  end

  // One multiplexer, answer one cycle after the request
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h00000000;
      done_r  <= 1'b0;
    end else begin
      done_r <= rd & local_area;
      if (rd && local_area) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign done  = done_r | eng_done;
  assign rdata = done_r ? rdata_r : eng_rdata;

endmodule // session_test_block

module cpu_register_adapter #(
  parameter FIFO_W = 512
) (
  input  wire                     CLOCK,
  input  wire                     RSTN,
  input  wire [`WADDR_W-1:0]      AVS_ADDRESS,
  input  wire                     AVS_WRITE,
  input  wire                     AVS_READ,
  input  wire [31:0]              AVS_WRITEDATA,
  input  wire [`LANES-1:0]        AVS_BYTEENABLE,
  output wire                     SLAVE_STALL_REQUEST,
  output wire [31:0]              AVS_READDATA,
  output wire [3:0]               ENG_WRITE_STROBE,
  output wire [4*`LOC_AW-1:0]     ENG_WORD_ADDRESS,
  output wire [4*32-1:0]          ENG_WRITE_WORD,
  output wire [4*`LANES-1:0]      ENG_LANE_MASK,
  output wire [3:0]               ENG_READ_REQUEST,
  input  wire [4*32-1:0]          ENG_READ_WORD,
  input  wire [3:0]               ENG_READ_DONE,
  output wire [3:0]               TX_FIFO_WRITE,
  output wire [4*FIFO_W-1:0]      TX_FIFO_WORD,
  input  wire [3:0]               TX_FIFO_FULL,
  output wire [3:0]               RX_FIFO_READ,
  input  wire [4*FIFO_W-1:0]      RX_FIFO_WORD,
  input  wire [3:0]               RX_FIFO_EMPTY,
  output wire [3:0]               CHECK_FAIL
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_ISSUE = 2'h1;
  localparam [1:0] ST_WAIT  = 2'h2;
  localparam [1:0] ST_DONE  = 2'h3;

  reg  [1:0]          state_r;
  reg  [1:0]          state_nxt;
  reg                 cmd_is_rd_r;
  reg  [`WADDR_W-1:0] cmd_addr_r;
  reg  [31:0]         cmd_wdata_r;
  reg  [`LANES-1:0]   cmd_mask_r;
  reg  [1:0]          drain_r;
  reg  [31:0]         rdata_r;

  // Crossing stage, drives the register interface
  reg                 reg_write_strobe_r;
  reg                 reg_read_request_r;
  reg  [`WADDR_W-1:0] reg_word_address_r;
  reg  [31:0]         reg_write_word_r;
  reg  [`LANES-1:0]   reg_write_lane_mask_r;

  // Switch stage
  reg  [3:0]          sw_wr_r;
  reg  [3:0]          sw_rd_r;
  reg  [`WADDR_W-1:0] sw_addr_r;
  reg  [31:0]         sw_wdata_r;
  reg  [`LANES-1:0]   sw_mask_r;
  reg  [`SEL_W-1:0]   sw_sel_r;
  reg                 reg_read_done_r;
  reg  [31:0]         reg_read_word_r;

  wire [4*32-1:0]     ses_rdata;
  wire [3:0]          ses_done;

  function [3:0] session_onehot;
    input [`SEL_W-1:0] sel;
    begin
      session_onehot = 4'h1 << sel;
    end
  endfunction

  // Stall everything except the single completion cycle
  assign SLAVE_STALL_REQUEST = (state_r != ST_DONE);
  assign AVS_READDATA        = rdata_r;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (AVS_WRITE || AVS_READ) begin
          state_nxt = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (cmd_is_rd_r ? reg_read_done_r : (drain_r == 2'h0)) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_r     <= ST_IDLE;
      cmd_is_rd_r <= 1'b0;
      cmd_addr_r  <= {`WADDR_W{1'b0}};
      cmd_wdata_r <= 32'h00000000;
      cmd_mask_r  <= 4'h0;
      drain_r     <= 2'h0;
      rdata_r     <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
      // Read has priority if a master ever raises both
      if (state_r == ST_IDLE && (AVS_WRITE || AVS_READ)) begin
        cmd_is_rd_r <= AVS_READ;
        cmd_addr_r  <= AVS_ADDRESS;
        cmd_wdata_r <= AVS_WRITEDATA;
        cmd_mask_r  <= AVS_BYTEENABLE;
      end
      if (state_r == ST_ISSUE) begin
        drain_r <= `WR_DRAIN;
      end else if (drain_r != 2'h0) begin
        drain_r <= drain_r - 2'h1;
      end
      if (state_r == ST_WAIT && reg_read_done_r) begin
        rdata_r <= reg_read_word_r;
      end
    end
  end

  // Strobes pulse once; address and data stay until the next command
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      reg_write_strobe_r    <= 1'b0;
      reg_read_request_r    <= 1'b0;
      reg_word_address_r    <= {`WADDR_W{1'b0}};
      reg_write_word_r      <= 32'h00000000;
      reg_write_lane_mask_r <= 4'h0;
    end else begin
      reg_write_strobe_r <= (state_r == ST_ISSUE) & ~cmd_is_rd_r;
      reg_read_request_r <= (state_r == ST_ISSUE) & cmd_is_rd_r;
      if (state_r == ST_ISSUE) begin
        reg_word_address_r    <= cmd_addr_r;
        reg_write_word_r      <= cmd_wdata_r;
        reg_write_lane_mask_r <= cmd_mask_r;
      end
    end
  end

  // Switch: registered decode of the session field
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      sw_wr_r         <= 4'h0;
      sw_rd_r         <= 4'h0;
      sw_addr_r       <= {`WADDR_W{1'b0}};
      sw_wdata_r      <= 32'h00000000;
      sw_mask_r       <= 4'h0;
      sw_sel_r        <= 2'h0;
      reg_read_done_r <= 1'b0;
      reg_read_word_r <= 32'h00000000;
    end else begin
      sw_wr_r <= {4{reg_write_strobe_r}} &
        session_onehot(reg_word_address_r[`SEL_HI:`SEL_LO]);
      sw_rd_r <= {4{reg_read_request_r}} &
        session_onehot(reg_word_address_r[`SEL_HI:`SEL_LO]);
      if (reg_write_strobe_r || reg_read_request_r) begin
        sw_addr_r  <= reg_word_address_r;
        sw_wdata_r <= reg_write_word_r;
        sw_mask_r  <= reg_write_lane_mask_r;
        sw_sel_r   <= reg_word_address_r[`SEL_HI:`SEL_LO];
      end
      reg_read_done_r <= ses_done[sw_sel_r] & cmd_is_rd_r;
      reg_read_word_r <= ses_rdata[sw_sel_r*32 +: 32];
    end
  end

  genvar s;
  generate
    for (s = 0; s < 4; s = s + 1) begin : g_ses
      session_test_block #(
        .FIFO_W (FIFO_W)
      ) u_ses (
        .clk       (CLOCK),
        .rst_n     (RSTN),
        .wr        (sw_wr_r[s]),
        .rd        (sw_rd_r[s]),
        .addr      (sw_addr_r),
        .wdata     (sw_wdata_r),
        .mask      (sw_mask_r),
        .eng_wr    (ENG_WRITE_STROBE[s]),
        .eng_addr  (ENG_WORD_ADDRESS[s*`LOC_AW +: `LOC_AW]),
        .eng_wdata (ENG_WRITE_WORD[s*32 +: 32]),
        .eng_mask  (ENG_LANE_MASK[s*`LANES +: `LANES]),
        .eng_rd    (ENG_READ_REQUEST[s]),
        .eng_rdata (ENG_READ_WORD[s*32 +: 32]),
        .eng_done  (ENG_READ_DONE[s]),
        .rdata     (ses_rdata[s*32 +: 32]),
        .done      (ses_done[s]),
        .tx_write  (TX_FIFO_WRITE[s]),
        .tx_word   (TX_FIFO_WORD[s*FIFO_W +: FIFO_W]),
        .tx_full   (TX_FIFO_FULL[s]),
        .rx_read   (RX_FIFO_READ[s]),
        .rx_word   (RX_FIFO_WORD[s*FIFO_W +: FIFO_W]),
        .rx_empty  (RX_FIFO_EMPTY[s]),
        .fail      (CHECK_FAIL[s])
      );
    end
  endgenerate

endmodule // cpu_register_adapter

// [verification/cpu_register_adapter_asserts.sv]
// Port-level checker for the four-session register bridge
`timescale 1ns/100ps
`include "reg_bridge_consts.vh"
module bridge_checker #(
  parameter FIFO_W = 512
) (
  input wire                 CLOCK,
  input wire                 RSTN,
  input wire                 AVS_WRITE,
  input wire                 AVS_READ,
  input wire                 SLAVE_STALL_REQUEST,
  input wire [3:0]           ENG_WRITE_STROBE,
  input wire [4*`LOC_AW-1:0] ENG_WORD_ADDRESS,
  input wire [3:0]           ENG_READ_REQUEST,
  input wire [3:0]           TX_FIFO_WRITE,
  input wire [3:0]           TX_FIFO_FULL,
  input wire [3:0]           RX_FIFO_READ,
  input wire [3:0]           RX_FIFO_EMPTY
);
  reg rd_pend_r;
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN)
      rd_pend_r <= 1'b0;
    else if (|ENG_READ_REQUEST)
      rd_pend_r <= 1'b1;
    else if (!SLAVE_STALL_REQUEST)
      rd_pend_r <= 1'b0;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  sequence s_wr_go; |ENG_WRITE_STROBE; endsequence
  sequence s_rd_go; |ENG_READ_REQUEST; endsequence
  sequence s_end; !SLAVE_STALL_REQUEST; endsequence
  a_stall_one_low: assert property ($fell(SLAVE_STALL_REQUEST) |=>
    SLAVE_STALL_REQUEST) else $error("stall low too long");
  a_write_ends: assert property (s_wr_go |-> ##[1:3] s_end)
    else $error("write did not finish");
  a_read_ends: assert property (s_rd_go |-> ##[1:24] s_end)
    else $error("read did not finish");
  a_wr_cmd: assert property (s_wr_go |-> AVS_WRITE &&
    SLAVE_STALL_REQUEST) else $error("strobe without write");
  a_rd_cmd: assert property (s_rd_go |-> AVS_READ)
    else $error("request without read");
  a_one_session: assert property ($onehot0(ENG_WRITE_STROBE |
    ENG_READ_REQUEST)) else $error("two session accesses");
  a_addr_hold: assert property (rd_pend_r |->
    $stable(ENG_WORD_ADDRESS)) else $error("address moved in read");
  a_tx_gate: assert property ((TX_FIFO_WRITE & TX_FIFO_FULL)
    == 4'h0) else $error("write into full fifo");
  a_rx_gate: assert property ((RX_FIFO_READ & RX_FIFO_EMPTY)
    == 4'h0) else $error("read from empty fifo");
  a_wr_rd_apart: assert property (!((|ENG_WRITE_STROBE) &&
    (|ENG_READ_REQUEST))) else $error("write and read together");
endmodule // bridge_checker
bind cpu_register_adapter bridge_checker #(.FIFO_W(FIFO_W)) u_chk (
  .CLOCK(CLOCK), .RSTN(RSTN), .AVS_WRITE(AVS_WRITE), .AVS_READ(AVS_READ),
  .SLAVE_STALL_REQUEST(SLAVE_STALL_REQUEST),
  .ENG_WRITE_STROBE(ENG_WRITE_STROBE), .ENG_WORD_ADDRESS(ENG_WORD_ADDRESS),
  .ENG_READ_REQUEST(ENG_READ_REQUEST), .TX_FIFO_WRITE(TX_FIFO_WRITE),
  .TX_FIFO_FULL(TX_FIFO_FULL), .RX_FIFO_READ(RX_FIFO_READ),
  .RX_FIFO_EMPTY(RX_FIFO_EMPTY));

// [verification/eng_slave_model.sv]
// Engine-side register slave model for the four sessions
`timescale 1ns/100ps
module eng_slave_model (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [3:0]   req,
  input  wire [23:0]  addr,
  input  wire [3:0]   noise,
  input  wire [3:0]   lat,
  output reg  [3:0]   done,
  output reg  [127:0] word
);
  reg [4:0] cnt_r;
  reg [1:0] sel_r;
  integer   i;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 5'h00;
      sel_r <= 2'h0;
      done  <= 4'h0;
      word  <= 128'h0;
    end else begin
      done <= 4'h0;
      // Idle bus toggles so a stale word never matches
      word <= ~word;
      if (|req) begin
        cnt_r <= {1'b0, lat} + 5'h01;
        sel_r <= {req[3] | req[2], req[3] | req[1]};
      end else if (cnt_r != 5'h00)
        cnt_r <= cnt_r - 5'h01;
      if (cnt_r == 5'h01) begin
        for (i = 0; i < 4; i = i + 1) begin
          done[i] <= (i == sel_r) | noise[i];
          word[i*32+:32] <= {16'hC0DE, 6'h00, i[1:0], 2'h0, addr[i*6+:6]};
        end
      end
    end
  end
endmodule // eng_slave_model

// [verification/cpu_register_adapter_tb_top.sv]
// Self-checking bench for the four-session register bridge
`timescale 1ns/100ps
`include "reg_bridge_consts.vh"
`define CHK(n, e, g) begin checks_done = checks_done + 1; \
  if ((g) !== (e)) begin n_errors = n_errors + 1; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module cpu_register_adapter_tb_top;
  localparam FW = 64;
  reg             CLOCK, RSTN, AVS_WRITE, AVS_READ, bad;
  reg [12:0]      AVS_ADDRESS;
  reg [31:0]      AVS_WRITEDATA, d, q, r32, rr;
  reg [3:0]       AVS_BYTEENABLE, TX_FIFO_FULL, RX_FIFO_EMPTY, noise, lat, be;
  reg [4*FW-1:0]  RX_FIFO_WORD;
  reg [3:0]       stb_seen;
  reg [23:0]      a_seen;
  reg [127:0]     w_seen;
  reg [15:0]      m_seen;
  reg [5:0]       a6;
  wire            SLAVE_STALL_REQUEST;
  wire [31:0]     AVS_READDATA;
  wire [3:0]      ENG_WRITE_STROBE, ENG_READ_REQUEST, ENG_READ_DONE;
  wire [3:0]      TX_FIFO_WRITE, RX_FIFO_READ, CHECK_FAIL;
  wire [23:0]     ENG_WORD_ADDRESS;
  wire [127:0]    ENG_WRITE_WORD, ENG_READ_WORD;
  wire [15:0]     ENG_LANE_MASK;
  wire [4*FW-1:0] TX_FIFO_WORD;
  integer         n_errors, checks_done, seed, txn, rxn, i, k, ncyc;
  function [31:0] eng_val(input [1:0] s, input [5:0] a);
    eng_val = {16'hC0DE, 6'h00, s, 2'h0, a};
  endfunction
  function [FW-1:0] pat(input [31:0] n);
    pat = {n + 32'h1, n};
  endfunction
  function [12:0] wa(input [1:0] s, input ar, input [5:0] x);
    wa = {s, ar, 4'h0, x};
  endfunction
  cpu_register_adapter #(.FIFO_W(FW)) DUT (.CLOCK(CLOCK), .RSTN(RSTN),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE), .AVS_READ(AVS_READ),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .SLAVE_STALL_REQUEST(SLAVE_STALL_REQUEST), .AVS_READDATA(AVS_READDATA),
    .ENG_WRITE_STROBE(ENG_WRITE_STROBE), .ENG_WORD_ADDRESS(ENG_WORD_ADDRESS),
    .ENG_WRITE_WORD(ENG_WRITE_WORD), .ENG_LANE_MASK(ENG_LANE_MASK),
    .ENG_READ_REQUEST(ENG_READ_REQUEST), .ENG_READ_WORD(ENG_READ_WORD),
    .ENG_READ_DONE(ENG_READ_DONE), .TX_FIFO_WRITE(TX_FIFO_WRITE),
    .TX_FIFO_WORD(TX_FIFO_WORD), .TX_FIFO_FULL(TX_FIFO_FULL),
    .RX_FIFO_READ(RX_FIFO_READ), .RX_FIFO_WORD(RX_FIFO_WORD),
    .RX_FIFO_EMPTY(RX_FIFO_EMPTY), .CHECK_FAIL(CHECK_FAIL));
  eng_slave_model u_eng (.clk(CLOCK), .rst_n(RSTN), .req(ENG_READ_REQUEST),
    .addr(ENG_WORD_ADDRESS), .noise(noise), .lat(lat),
    .done(ENG_READ_DONE), .word(ENG_READ_WORD));
  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    if (|ENG_WRITE_STROBE) begin
      stb_seen <= ENG_WRITE_STROBE;
      a_seen <= ENG_WORD_ADDRESS;
      w_seen <= ENG_WRITE_WORD;
      m_seen <= ENG_LANE_MASK;
    end
    r32 = $random(seed);
    // Quiet FIFOs in reset; only session 2 ever has receive data
    TX_FIFO_FULL <= RSTN ? r32[3:0] : 4'h0;
    RX_FIFO_EMPTY <= {1'b1, r32[4] | !RSTN, 2'h3};
    if (TX_FIFO_WRITE[1] === 1'b1) begin
      `CHK("tx word", pat(txn), TX_FIFO_WORD[FW+:FW])
      txn = txn + 1;
    end
    if (!RSTN) begin
      RX_FIFO_WORD <= {4*FW{1'b0}};
    end else if (RX_FIFO_READ[2] === 1'b1) begin
      RX_FIFO_WORD[2*FW+:FW] <= pat(rxn) ^ {FW{bad}};
      rxn = rxn + 1;
    end
  end
  task close_out;
    begin
      if (n_errors == 0 && checks_done > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task guard(input integer kk);
    begin
      if (kk >= 200) begin
        n_errors = n_errors + 1;
        close_out;
      end
    end
  endtask
  // Holds the command until stall is sampled low, as the bus requires
  task xfer(input w, input [12:0] a, input [31:0] dv, input [3:0] bv);
    integer n;
    begin
      @(posedge CLOCK);
      AVS_ADDRESS <= a;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      AVS_WRITEDATA <= dv;
      AVS_BYTEENABLE <= bv;
      n = 0;
      @(posedge CLOCK);
      while (SLAVE_STALL_REQUEST !== 1'b0 && n < 200) begin
        @(posedge CLOCK);
        n = n + 1;
      end
      guard(n);
      ncyc = n;
      q = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
    end
  endtask
  initial begin
    seed = 1430;
    {n_errors, checks_done, txn, rxn} = 0;
    {RSTN, AVS_WRITE, AVS_READ, bad, AVS_ADDRESS, AVS_WRITEDATA} = 0;
    {AVS_BYTEENABLE, noise, lat} = 0;
    repeat (12) @(posedge CLOCK);
    RSTN <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      d = $random(seed);
      rr = $random(seed);
      be = rr[3:0];
      a6 = (i == 3) ? 6'h3F : rr[9:4];
      xfer(1'b1, wa(i[1:0], 1'b0, a6), d, be);
      `CHK("wr cycles", 5, ncyc)
      `CHK("wr lane", 4'h1 << i, stb_seen)
      `CHK("wr addr", a6, a_seen[i*6+:6])
      `CHK("wr data", d, w_seen[i*32+:32])
      `CHK("wr mask", be, m_seen[i*4+:4])
      // Other sessions answer too; only the selected one may count
      rr = $random(seed);
      noise <= rr[3:0];
      lat <= rr[7:4];
      xfer(1'b0, wa(i[1:0], 1'b0, a6), 32'h0, 4'h0);
      `CHK("rd data", eng_val(i[1:0], a6), q)
      `CHK("eng rd cycles", lat + 7, ncyc)
    end
    d = $random(seed);
    xfer(1'b1, wa(2'h0, 1'b1, `LREG_TXLEN), d, 4'h0);
    xfer(1'b0, wa(2'h0, 1'b1, `LREG_TXLEN), 32'h0, 4'h0);
    `CHK("txlen", d, q)
    `CHK("rd cycles", 6, ncyc)
    xfer(1'b0, wa(2'h3, 1'b1, 6'h2A), 32'h0, 4'h0);
    `CHK("unmapped", 32'h0, q)
    xfer(1'b1, wa(2'h1, 1'b1, `LREG_TXLEN), 32'h3, 4'hF);
    txn = 0;
    xfer(1'b1, wa(2'h1, 1'b1, `LREG_CTRL), 32'h1, 4'hF);
    for (k = 0; txn < 3 && k < 200; k = k + 1)
      @(posedge CLOCK);
    guard(k);
    xfer(1'b0, wa(2'h1, 1'b1, `LREG_TXCNT), 32'h0, 4'h0);
    `CHK("txcnt", 32'h3, q)
    `CHK("tx words", 3, txn)
    xfer(1'b1, wa(2'h2, 1'b1, `LREG_CTRL), 32'h2, 4'hF);
    for (k = 0; rxn < 6 && k < 200; k = k + 1)
      @(posedge CLOCK);
    guard(k);
    `CHK("fail clean", 4'h0, CHECK_FAIL)
    bad = 1'b1;
    for (k = 0; rxn < 8 && k < 200; k = k + 1)
      @(posedge CLOCK);
    guard(k);
    bad = 1'b0;
    xfer(1'b0, wa(2'h2, 1'b1, `LREG_STAT), 32'h0, 4'h0);
    `CHK("stat fail", 1'b1, q[`STAT_FAIL])
    `CHK("fail pin", 4'h4, CHECK_FAIL)
    close_out;
  end
endmodule // cpu_register_adapter_tb_top
